// File: include/aicr_defs.svh
// constants for the input configuration register block
`ifndef AICR_DEFS_SVH
`define AICR_DEFS_SVH
`define AICR_SEL_HI 11
`define AICR_SEL_LO 10
`define AICR_SEL_WORD0 2'h0
`define AICR_BIT_REF 0
`define AICR_BIT_PD 2
`define AICR_CFG_HI 7
`define AICR_CFG_LO 3
`define AICR_TEST_HI 9
`define AICR_TEST_LO 8
`define AICR_RESET_WORD 10'h020
`define AICR_WORD_MASK 10'h3FD
`define AICR_MID_CODE 12'h800
`define AICR_FULL_CODE 12'hFFF
`define AICR_ZERO_CODE 12'h000
`endif

// File: include/aicr_pkg.sv
// types for the input configuration register block
package aicr_pkg;
  typedef enum logic [3:0] {
    AICR_IN_AP = 4'h1,
    AICR_IN_AM = 4'h2,
    AICR_IN_BP = 4'h4,
    AICR_IN_BM = 4'h8
  } aicr_input_t;
  typedef enum logic [3:0] {
    AICR_T_NORMAL = 4'h1,
    AICR_T_TOP = 4'h2,
    AICR_T_MID = 4'h4,
    AICR_T_BOTTOM = 4'h8
  } aicr_test_t;
endpackage

// File: src/aicr_seq.sv
// channel sequence decoder for one configuration code and step
`timescale 1ns/1ns
module aicr_seq (
  input wire logic [4:0] cfg_in,
  input wire logic [1:0] step_in,
  output logic [3:0] pos_out,
  output logic [3:0] neg_out,
  output logic [1:0] last_out,
  output logic multi_out
);
  ////////////////////////////////////////////////////////////////////////
  // one-hot positive and negative input per step; zero neg means single-ended
  always_comb begin
    pos_out = 4'h0;
    neg_out = 4'h0;
    last_out = 2'h0;
    multi_out = 1'b0;
    case (cfg_in)
      5'h00: pos_out = aicr_pkg::AICR_IN_AP;
      5'h01: pos_out = aicr_pkg::AICR_IN_AM;
      5'h02: pos_out = aicr_pkg::AICR_IN_BP;
      5'h03: pos_out = aicr_pkg::AICR_IN_BM;
      5'h04: begin
        pos_out = aicr_pkg::AICR_IN_AP;
        neg_out = aicr_pkg::AICR_IN_AM;
      end
      5'h05: begin
        pos_out = aicr_pkg::AICR_IN_BP;
        neg_out = aicr_pkg::AICR_IN_BM;
      end
      5'h11, 5'h12, 5'h13: begin
        multi_out = 1'b1;
        last_out = cfg_in[1:0];
        case (step_in)
          2'h0: pos_out = aicr_pkg::AICR_IN_AP;
          2'h1: pos_out = aicr_pkg::AICR_IN_AM;
          2'h2: pos_out = aicr_pkg::AICR_IN_BP;
          default: pos_out = aicr_pkg::AICR_IN_BM;
        endcase
      end
      5'h15: begin
        multi_out = 1'b1;
        last_out = 2'h1;
        if (step_in == 2'h0) begin
          pos_out = aicr_pkg::AICR_IN_AP;
        end else begin
          pos_out = aicr_pkg::AICR_IN_BP;
          neg_out = aicr_pkg::AICR_IN_BM;
        end
      end
      5'h16: begin
        multi_out = 1'b1;
        last_out = 2'h2;
        case (step_in)
          2'h0: pos_out = aicr_pkg::AICR_IN_AP;
          2'h1: pos_out = aicr_pkg::AICR_IN_AM;
          default: begin
            pos_out = aicr_pkg::AICR_IN_BP;
            neg_out = aicr_pkg::AICR_IN_BM;
          end
        endcase
      end
      5'h19: begin
        multi_out = 1'b1;
        last_out = 2'h1;
        if (step_in == 2'h0) begin
          pos_out = aicr_pkg::AICR_IN_AP;
          neg_out = aicr_pkg::AICR_IN_AM;
        end else begin
          pos_out = aicr_pkg::AICR_IN_BP;
          neg_out = aicr_pkg::AICR_IN_BM;
        end
      end
      default: begin
        pos_out = 4'h0; // reserved code: nothing selected
      end
    endcase
  end
endmodule

// File: src/aicr_top.sv
// input configuration word register with channel sequencing and output coding
`timescale 1ns/1ns
`include "aicr_defs.svh"
module aicr_top (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic wr_strobe_in,
  input wire logic [11:0] wr_data_in,
  input wire logic conv_done_in,
  input wire logic [11:0] conv_result_in,
  input wire logic twos_format_in,
  output logic ext_ref_out,
  output logic power_down_out,
  output logic [3:0] sel_pos_out,
  output logic [3:0] sel_neg_out,
  output logic [3:0] test_level_out,
  output logic [11:0] result_out,
  output logic first_chan_n_out,
  output logic [9:0] config_word_out
);
  logic [9:0] word_q;
  logic [9:0] word_d;
  logic [1:0] step_q;
  logic [1:0] step_d;
  logic [3:0] seq_pos;
  logic [3:0] seq_neg;
  logic [1:0] seq_last;
  logic seq_multi;
  logic ext_ref_q;
  logic pd_q;
  logic [3:0] pos_q;
  logic [3:0] neg_q;
  logic [3:0] test_q;
  logic [11:0] result_q;
  logic first_n_q;
  logic [11:0] result_d;
  logic first_n_d;
  logic [3:0] test_d;
  logic write_word0;
  logic ext_ref_d;
  logic pd_d;
  logic [3:0] pos_d;
  logic [3:0] neg_d;

  ////////////////////////////////////////////////////////////////////////
  // register select decode; writes accepted even in power-down
  always_comb begin
    write_word0 = 1'b0;
    if (wr_strobe_in) begin
      case (wr_data_in[`AICR_SEL_HI:`AICR_SEL_LO])
        `AICR_SEL_WORD0: write_word0 = 1'b1;
        default: write_word0 = 1'b0; // other register or reserved select
      endcase
    end
  end

  // next value of the configuration word, reserved bit forced low
  always_comb begin
    word_d = word_q;
    if (write_word0) begin
      word_d = wr_data_in[9:0] & `AICR_WORD_MASK;
    end
  end

  // configuration word storage
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      word_q <= `AICR_RESET_WORD;
    end else begin
      word_q <= word_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence decoder for the current configuration
  aicr_seq u_seq (
    .cfg_in(word_q[`AICR_CFG_HI:`AICR_CFG_LO]),
    .step_in(step_q),
    .pos_out(seq_pos),
    .neg_out(seq_neg),
    .last_out(seq_last),
    .multi_out(seq_multi)
  );

  // sweep step advances per finished conversion unless the stored word has power-down set, restarts on rewrite
  always_comb begin
    step_d = step_q;
    if (write_word0 || !seq_multi) begin
      step_d = 2'h0;
    end else if (conv_done_in && !word_q[`AICR_BIT_PD]) begin
      step_d = (step_q >= seq_last) ? 2'h0 : step_q + 2'h1;
    end
  end

  // step counter
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      step_q <= 2'h0;
    end else begin
      step_q <= step_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // test level decode
  always_comb begin
    case (word_q[`AICR_TEST_HI:`AICR_TEST_LO])
      2'h0: test_d = aicr_pkg::AICR_T_NORMAL;
      2'h1: test_d = aicr_pkg::AICR_T_TOP;
      2'h2: test_d = aicr_pkg::AICR_T_MID;
      default: test_d = aicr_pkg::AICR_T_BOTTOM;
    endcase
  end

  // result coding and first-channel marker, captured per conversion
  always_comb begin
    result_d = result_q;
    first_n_d = first_n_q;
    if (!seq_multi) begin
      first_n_d = 1'b1;
    end
    if (conv_done_in) begin
      result_d = twos_format_in ? (conv_result_in ^ `AICR_MID_CODE) : conv_result_in;
      first_n_d = !(seq_multi && step_q == 2'h0);
    end
  end

  // result and marker flops
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      result_q <= `AICR_ZERO_CODE;
      first_n_q <= 1'b1;
    end else begin
      result_q <= result_d;
      first_n_q <= first_n_d;
    end
  end

  // test level flops
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      test_q <= aicr_pkg::AICR_T_NORMAL;
    end else begin
      test_q <= test_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reference and power-down follow the stored word
  always_comb begin
    ext_ref_d = word_q[`AICR_BIT_REF];
    pd_d = word_q[`AICR_BIT_PD];
  end

  // reference and power-down flops
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ext_ref_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      ext_ref_q <= ext_ref_d;
      pd_q <= pd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // selected inputs follow the decoder, one cycle behind the step
  always_comb begin
    pos_d = seq_pos;
    neg_d = seq_neg; // zero when single-ended
  end

  // input selection flops
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pos_q <= 4'h0;
      neg_q <= 4'h0;
    end else begin
      pos_q <= pos_d;
      neg_q <= neg_d;
    end
  end

  assign ext_ref_out = ext_ref_q;
  assign power_down_out = pd_q;
  assign sel_pos_out = pos_q;
  assign sel_neg_out = neg_q;
  assign test_level_out = test_q;
  assign result_out = result_q;
  assign first_chan_n_out = first_n_q;
  assign config_word_out = word_q; // readback path, live in power-down
endmodule

// File: sim/aicr_props.sv
// port assertions for the configuration block
`timescale 1ns/1ns
module aicr_props (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic wr_strobe_in,
  input wire logic [11:0] wr_data_in,
  input wire logic conv_done_in,
  input wire logic [11:0] conv_result_in,
  input wire logic twos_format_in,
  input wire logic ext_ref_out,
  input wire logic power_down_out,
  input wire logic [3:0] sel_pos_out,
  input wire logic [3:0] sel_neg_out,
  input wire logic [3:0] test_level_out,
  input wire logic [11:0] result_out,
  input wire logic first_chan_n_out,
  input wire logic [9:0] config_word_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  logic wr0;
  logic [11:0] d;
  // accepted word write and its data
  assign wr0 = wr_strobe_in && wr_data_in[11:10] == 2'h0;
  assign d = wr_data_in;
  sequence s_reload;
    config_word_out == 10'h020 ##1 sel_pos_out == 4'h1 && sel_neg_out == 4'h2;
  endsequence
  sequence s_sweep;
    wr0 && d[7] ##1 !conv_done_in ##1 conv_done_in && !power_down_out;
  endsequence
  a_reset_load: assert property (
    $fell(reset_in) |-> s_reload) else $error("reload");
  a_word_load: assert property (
    wr0 |=> config_word_out == ($past(d[9:0]) & 10'h3FD)) else $error("word");
  a_ref_pd: assert property (
    wr0 |-> ##2 ext_ref_out == $past(d[0], 2) && power_down_out == $past(d[2], 2))
    else $error("ref or pd");
  a_test_level: assert property (
    wr0 |-> ##2 test_level_out == (4'h1 << $past(d[9:8], 2))) else $error("test");
  a_single_pick: assert property (
    wr0 && d[7:5] == 3'h0 |-> ##2 sel_neg_out == 4'h0 && sel_pos_out == (4'h1 << $past(d[4:3], 2)))
    else $error("single");
  a_pair_pick: assert property (
    wr0 && d[7:4] == 4'h2 |-> ##2 sel_pos_out == ($past(d[3], 2) ? 4'h4 : 4'h1)
    && sel_neg_out == (sel_pos_out << 1)) else $error("pair");
  a_result_code: assert property (
    conv_done_in && !power_down_out |=> result_out == ($past(conv_result_in)
    ^ {$past(twos_format_in), 11'h000})) else $error("result");
  a_sweep_mark: assert property (
    s_sweep |=> !first_chan_n_out) else $error("marker");
endmodule

// File: sim/aicr_host.sv
// host model: register writes and conversion results
`timescale 1ns/1ns
module aicr_host (
  input wire logic clk_in,
  output logic wr_strobe_out = 1'b0,
  output logic [11:0] wr_data_out = 12'h000,
  output logic conv_done_out = 1'b0,
  output logic [11:0] conv_result_out = 12'h000,
  output logic twos_out = 1'b0
);
  // one write (s high) or one conversion; released lines show the inverse
  task cyc(input logic s, input logic [11:0] w, input logic t);
    @(posedge clk_in);
    #1 wr_strobe_out = s;
    conv_done_out = !s;
    wr_data_out = w;
    conv_result_out = w;
    twos_out = t;
    @(posedge clk_in);
    #1 wr_strobe_out = 1'b0;
    conv_done_out = 1'b0;
    wr_data_out = ~w;
    conv_result_out = ~w;
  endtask
endmodule

// File: sim/testbench.sv
// self-checking bench for the configuration block
`timescale 1ns/1ns
module testbench;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic cv = 1'b0;
  logic ws, cd, tw, er, pd, fn;
  logic [11:0] wd, cr, rs;
  logic [3:0] sp, sn, tl;
  logic [9:0] cw;
  logic [7:0] se;
  logic [15:0] last;
  logic [31:0] rnd = 32'hFE3B236E;
  logic [20:0] notes[$];
  logic [4:0] codes[12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
    5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h19};
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #4 clk_in = ~clk_in;
  aicr_host u_host (.clk_in(clk_in), .wr_strobe_out(ws), .wr_data_out(wd),
    .conv_done_out(cd), .conv_result_out(cr), .twos_out(tw));
  aicr_top dut (.clk_in(clk_in), .reset_in(reset_in), .wr_strobe_in(ws), .wr_data_in(wd),
    .conv_done_in(cd), .conv_result_in(cr), .twos_format_in(tw), .ext_ref_out(er),
    .power_down_out(pd), .sel_pos_out(sp), .sel_neg_out(sn), .test_level_out(tl),
    .result_out(rs), .first_chan_n_out(fn), .config_word_out(cw));
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // {pos, neg} per step, step 0 in the low byte
  function logic [31:0] seqw(input logic [4:0] c);
    case (c)
      5'h04: return 32'h12;
      5'h05: return 32'h48;
      5'h11: return 32'h2010;
      5'h12: return 32'h402010;
      5'h13: return 32'h80402010;
      5'h15: return 32'h4810;
      5'h16: return 32'h482010;
      5'h19: return 32'h4812;
      default: return 32'h10 << c;
    endcase
  endfunction
  task chk_cfg(input logic [15:0] e);
    samples_checked++;
    if ({cw, er, pd, tl} !== e) begin
      errors++;
      $display("CHECK FAILED config expected %h seen %h", e, {cw, er, pd, tl});
    end
  endtask
  task chk_conv(input logic [20:0] s);
    logic [20:0] e;
    samples_checked++;
    if (notes.size() == 0) begin
      errors++;
      $display("CHECK FAILED conversion expected none seen %h", s);
    end else begin
      e = notes.pop_front();
      if (s !== e) begin
        errors++;
        $display("CHECK FAILED conversion expected %h seen %h", e, s);
      end
    end
  endtask
  // n conversions, each noted before it is sent
  task convs(input logic [31:0] w, input int n);
    int len, k;
    len = 1 + (w[15:8] != 0) + (w[23:16] != 0) + (w[31:24] != 0);
    for (k = 0; k < n; k++) begin
      rnd = lfsr(rnd);
      notes.push_back({w[8 * (k % len) +: 8], !(len > 1 && k % len == 0),
        rnd[11:0] ^ {rnd[12], 11'h000}});
      u_host.cyc(1'b0, rnd[11:0], rnd[12]);
    end
  endtask
  task run(input logic [11:0] d, input int n);
    u_host.cyc(1'b1, d, tw);
    convs(seqw(d[7:3]), n);
    last = {d[9:0] & 10'h3FD, d[0], d[2], 4'h1 << d[9:8]};
    repeat (2) @(posedge clk_in);
    #1 chk_cfg(last);
  endtask
  task conclude();
    errors += notes.size();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // result watcher and run limit
  always @(posedge clk_in) begin
    if (cv) chk_conv({se, fn, rs});
    cv <= cd;
    se <= {sp, sn};
    cycles <= cycles + 1;
    if (cycles > 4000) begin
      errors++;
      conclude();
    end
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk_in);
    #1 reset_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1 chk_cfg(16'h0801);
    convs(32'h12, 2);
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      run({2'h0, i[1:0], codes[i], 1'b0, rnd[1:0]}, 9);
    end
    for (int j = 1; j < 4; j++) u_host.cyc(1'b1, {j[1:0], 10'h3FF}, tw);
    repeat (2) @(posedge clk_in);
    #1 chk_cfg(last);
    run(12'h004, 0);
    run(12'h100, 1);
    repeat (4) @(posedge clk_in);
    conclude();
  end
endmodule
bind aicr_top aicr_props u_props (.clk_in(clk_in), .reset_in(reset_in),
  .wr_strobe_in(wr_strobe_in), .wr_data_in(wr_data_in), .conv_done_in(conv_done_in),
  .conv_result_in(conv_result_in), .twos_format_in(twos_format_in),
  .ext_ref_out(ext_ref_out), .power_down_out(power_down_out), .sel_pos_out(sel_pos_out),
  .sel_neg_out(sel_neg_out), .test_level_out(test_level_out), .result_out(result_out),
  .first_chan_n_out(first_chan_n_out), .config_word_out(config_word_out));
